// ### src/psc_pkg.sv
// Call unit constants and types
package psc_pkg;
    // ========================================
    // Widths and counts
    localparam int DW = 64;            // Data word width
    localparam int IPLW = 3;           // Priority level width
    localparam int NVAR = 4;           // Known image variants
    localparam int NVEC = 6;           // Entry vectors
    localparam int CPUW = 6;           // Processor number width
    localparam int MCW = 5;            // Check summary width

    // ========================================
    // Call codes
    typedef enum logic [3:0] {
        C_SWPIPL = 4'h0,
        C_SWPIMG = 4'h1,
        C_TBINV  = 4'h2,
        C_WHOAMI = 4'h3,
        C_WRVEC  = 4'h4,
        C_WRFLT  = 4'h5,
        C_WRIPI  = 4'h6,
        C_WRKGP  = 4'h7,
        C_WRMCS  = 4'h8,
        C_PERF   = 4'h9,
        C_WRUSP  = 4'hA,
        C_WRVAL  = 4'hB,
        C_WRVPT  = 4'hC,
        C_RDVAL  = 4'hD
    } psc_call_t;

    // Image swap sequence states
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FLUSH = 2'b01,
        S_INIT  = 2'b10
    } psc_state_t;

    // ========================================
    // Field positions and values
    localparam int VAR_LIMIT = 256;       // Below: variant id
    localparam logic [1:0] ST_OK = 2'h0;  // Swap done
    localparam logic [1:0] ST_UNK = 2'h1; // Unknown variant
    localparam logic [1:0] ST_NLD = 2'h2; // Not loaded
    localparam logic [DW-1:0] SEL_ISB = 64'h1;
    localparam logic [DW-1:0] SEL_DSB = 64'h2;
    localparam logic [DW-1:0] SEL_BSB = 64'h3;
    localparam logic [DW-1:0] SEL_NGL = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [DW-1:0] SEL_ALL = 64'hFFFF_FFFF_FFFF_FFFE;
    localparam logic [DW-1:0] PCB_FEN_OFS = 64'h28; // Byte 40
    localparam int MC_CLR_HI = 2;      // In-progress bits 0..2
    localparam int MC_EN_LO = 3;       // Enable bits 3..4
    localparam logic [IPLW-1:0] IPL_RST = 3'h7;
    localparam logic [MCW-1:0] MC_RST = 5'h00;
    localparam logic [DW-1:0] ZERO = 64'h0;
endpackage

// ### src/psc_image_sel.sv
// Image descriptor to status and base
module psc_image_sel (
    input  wire logic [63:0]  descriptor,
    input  wire logic [3:0]   loaded,
    input  wire logic [255:0] bases,
    output logic [1:0]        status,
    output logic [63:0]       base
);
    // ========================================
    // Variant lookup
    always_comb begin
        status = psc_pkg::ST_OK;
        base = descriptor;
        // [RULE4] small value is variant
        if (descriptor < 64'(psc_pkg::VAR_LIMIT)) begin
            // [RULE3] status codes
            if (descriptor >= 64'(psc_pkg::NVAR)) begin
                status = psc_pkg::ST_UNK;
            end else if (!loaded[descriptor[1:0]]) begin
                status = psc_pkg::ST_NLD;
            end else begin
                base = bases[descriptor[1:0]*64 +: 64];
            end
        end
    end
endmodule

// ### src/psc_tb_decode.sv
// Decodes the translation invalidate selector
module psc_tb_decode (
    input  wire logic [63:0] sel,
    output logic             invI,
    output logic             invD,
    output logic             dropLocal,
    output logic             flushAll
);
    // ========================================
    // Selector decode
    always_comb begin
        // [RULE7] single entry targets
        invI = (sel == psc_pkg::SEL_ISB) || (sel == psc_pkg::SEL_BSB);
        invD = (sel == psc_pkg::SEL_DSB) || (sel == psc_pkg::SEL_BSB);
        // [RULE8] whole buffer actions
        dropLocal = (sel == psc_pkg::SEL_NGL);
        flushAll = (sel == psc_pkg::SEL_ALL);
    end
endmodule

// ### src/psc_call_unit.sv
// Privileged call unit top
//
// How it works
// [RULE1] User mode call raises reserved opcode fault
// [RULE2] Priority swap returns old, loads a0 low
// [RULE3] Image swap status 0, 1 or 2
// [RULE4] Descriptor below 256 is a variant id
// [RULE5] Success flushes caches, buffers, then jumps
// [RULE6] Never loads images; registers left unpredictable
// [RULE7] Invalidate selector 1, 2, 3 by address
// [RULE8] Selector -1 locals, -2 all, else none
// [RULE9] Identity call returns processor number
// [RULE10] Entry vector write chosen by a1
// [RULE11] Float enable bit copied to block word
// [RULE12] Cross processor request posted to target
// [RULE13] Caller continues before request is taken
// [RULE14] Kernel pointer loads global pointer on exception
// [RULE15] Summary clears in-progress, loads enable bits
// [RULE16] Performance call forwards args, returns value
// [RULE17] User stack pointer write stores a0
// [RULE18] System value write, read returns it
// [RULE19] Page table pointer write stores a0
// [RULE20] Temporaries and used args become unpredictable
// [RULE21] Privilege check precedes every state change
module psc_call_unit (
    input  wire logic         clock,
    input  wire logic         rst_b,
    // Call request
    input  wire logic         callValid,
    input  wire logic [3:0]   callCode,
    input  wire logic [63:0]  arg0,
    input  wire logic [63:0]  arg1,
    input  wire logic         statusMode,
    // Machine environment
    input  wire logic [5:0]   cpuNumber,
    input  wire logic [63:0]  processBlockBase,
    input  wire logic [3:0]   imageLoaded,
    input  wire logic [255:0] imageBases,
    input  wire logic [2:0]   checkEvent,
    input  wire logic         exceptionTaken,
    input  wire logic [63:0]  perfResult,
    // Call answer
    output logic              callReady_ff,
    output logic              callDone_ff,
    output logic              reservedOpcodeFault_ff,
    output logic [63:0]       result_ff,
    // Processor state
    output logic [2:0]        interruptPriorityLevel_ff,
    output logic              floatEnable_ff,
    output logic [63:0]       kernelGlobalPointer_ff,
    output logic [63:0]       userStackPointer_ff,
    output logic [63:0]       systemValue_ff,
    output logic [63:0]       virtualTablePointer_ff,
    output logic [4:0]        machineCheckSummary_ff,
    output logic [383:0]      entryVector_ff,
    output logic              gpLoad_ff,
    output logic [63:0]       gpValue_ff,
    // Translation buffers and cache
    output logic              itbInvalidate_ff,
    output logic              dtbInvalidate_ff,
    output logic [63:0]       tbAddress_ff,
    output logic              tbDropLocal_ff,
    output logic              tbFlushAll_ff,
    output logic              icacheFlush_ff,
    // Image switch
    output logic              imageInit_ff,
    output logic              imageJump_ff,
    output logic [63:0]       imageEntry_ff,
    // Process block write
    output logic              pcbWrite_ff,
    output logic [63:0]       pcbAddress_ff,
    output logic              pcbData_ff,
    // Cross processor request
    output logic              crossCpuRequest_ff,
    output logic [63:0]       crossCpuTarget_ff,
    // Performance monitor
    output logic              perfRequest_ff,
    output logic [63:0]       perfArg0_ff,
    output logic [63:0]       perfArg1_ff
);
    // ========================================
    // Decode and privilege
    psc_pkg::psc_state_t state_ff;   // Swap sequence state
    logic [63:0]         jumpAddr_ff; // Resolved image base
    logic                take;       // Call accepted
    logic                ok;         // Call may act
    logic                isTbi;      // Invalidate call acts
    logic                takeImg;    // Image swap succeeds
    logic [1:0]          imgStatus;  // Resolver status
    logic [63:0]         imgBase;    // Resolver base
    logic                dInvI;      // Decoded selector
    logic                dInvD;
    logic                dLocal;
    logic                dAll;
    logic [63:0]         nxt_result; // Answer value

    assign take = callValid && callReady_ff;
    // [RULE21] gate all writes
    assign ok = take && !statusMode;
    assign isTbi = ok && callCode == psc_pkg::C_TBINV;
    assign takeImg = ok && callCode == psc_pkg::C_SWPIMG &&
                     imgStatus == psc_pkg::ST_OK;

    // Image descriptor resolver
    psc_image_sel uSel (
        .descriptor (arg0),
        .loaded     (imageLoaded),
        .bases      (imageBases),
        .status     (imgStatus),
        .base       (imgBase)
    );

    // Invalidate selector decoder
    psc_tb_decode uTb (
        .sel       (arg0),
        .invI      (dInvI),
        .invD      (dInvD),
        .dropLocal (dLocal),
        .flushAll  (dAll)
    );

    // ========================================
    // Answer value select
    // [RULE20] scratch registers are the caller's
    always_comb begin
        nxt_result = psc_pkg::ZERO;
        case (callCode)
            // [RULE2] old level returned
            psc_pkg::C_SWPIPL: begin
                nxt_result = {61'h0, interruptPriorityLevel_ff};
            end
            psc_pkg::C_SWPIMG: begin
                nxt_result = {62'h0, imgStatus};
            end
            // [RULE9] processor number
            psc_pkg::C_WHOAMI: begin
                nxt_result = {58'h0, cpuNumber};
            end
            // [RULE16] monitor answer
            psc_pkg::C_PERF: begin
                nxt_result = perfResult;
            end
            // [RULE18] read back value
            psc_pkg::C_RDVAL: begin
                nxt_result = systemValue_ff;
            end
            default: begin
                nxt_result = psc_pkg::ZERO;
            end
        endcase
    end

    // ========================================
    // Sequence and answer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= psc_pkg::S_IDLE;
            callReady_ff <= 1'b1;
            callDone_ff <= 1'b0;
            reservedOpcodeFault_ff <= 1'b0;
            result_ff <= psc_pkg::ZERO;
            jumpAddr_ff <= psc_pkg::ZERO;
        end else begin
            callDone_ff <= 1'b0;
            reservedOpcodeFault_ff <= 1'b0;
            case (state_ff)
                psc_pkg::S_IDLE: begin
                    // [RULE1] fault in user mode
                    if (take && statusMode) begin
                        reservedOpcodeFault_ff <= 1'b1;
                        callDone_ff <= 1'b1;
                    end else if (ok) begin
                        result_ff <= nxt_result;
                        jumpAddr_ff <= imgBase;
                        // [RULE5] start switch sequence
                        if (takeImg) begin
                            state_ff <= psc_pkg::S_FLUSH;
                            callReady_ff <= 1'b0;
                        end else begin
                            callDone_ff <= 1'b1;
                        end
                    end
                end
                psc_pkg::S_FLUSH: begin
                    state_ff <= psc_pkg::S_INIT;
                end
                psc_pkg::S_INIT: begin
                    state_ff <= psc_pkg::S_IDLE;
                    callReady_ff <= 1'b1;
                    callDone_ff <= 1'b1;
                end
                default: begin
                    state_ff <= psc_pkg::S_IDLE;
                    callReady_ff <= 1'b1;
                end
            endcase
        end
    end

    // ========================================
    // Image switch strobes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            icacheFlush_ff <= 1'b0;
            imageInit_ff <= 1'b0;
            imageJump_ff <= 1'b0;
            imageEntry_ff <= psc_pkg::ZERO;
        end else begin
            // [RULE5] flush, init, then jump
            icacheFlush_ff <= takeImg;
            imageInit_ff <= state_ff == psc_pkg::S_FLUSH;
            imageJump_ff <= state_ff == psc_pkg::S_INIT;
            // [RULE6] only the base is handed on
            if (state_ff == psc_pkg::S_INIT) begin
                imageEntry_ff <= jumpAddr_ff;
            end
        end
    end

    // ========================================
    // Translation buffer commands
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            itbInvalidate_ff <= 1'b0;
            dtbInvalidate_ff <= 1'b0;
            tbDropLocal_ff <= 1'b0;
            tbFlushAll_ff <= 1'b0;
            tbAddress_ff <= psc_pkg::ZERO;
        end else begin
            // [RULE7] per-address invalidates
            itbInvalidate_ff <= isTbi && dInvI;
            dtbInvalidate_ff <= isTbi && dInvD;
            // [RULE8] non-global drop
            tbDropLocal_ff <= isTbi && dLocal;
            // [RULE5] swap also flushes all
            tbFlushAll_ff <= (isTbi && dAll) || takeImg;
            if (isTbi) begin
                tbAddress_ff <= arg1;
            end
        end
    end

    // ========================================
    // Priority level and float enable
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            interruptPriorityLevel_ff <= psc_pkg::IPL_RST;
            floatEnable_ff <= 1'b0;
            pcbWrite_ff <= 1'b0;
            pcbAddress_ff <= psc_pkg::ZERO;
            pcbData_ff <= 1'b0;
        end else begin
            pcbWrite_ff <= 1'b0;
            // [RULE2] load new level
            if (ok && callCode == psc_pkg::C_SWPIPL) begin
                interruptPriorityLevel_ff <= arg0[2:0];
            end
            // [RULE11] enable and block copy
            if (ok && callCode == psc_pkg::C_WRFLT) begin
                floatEnable_ff <= arg0[0];
                pcbWrite_ff <= 1'b1;
                pcbAddress_ff <= processBlockBase +
                                 psc_pkg::PCB_FEN_OFS;
                pcbData_ff <= arg0[0];
            end
        end
    end

    // ========================================
    // Pointer and value registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            kernelGlobalPointer_ff <= psc_pkg::ZERO;
            userStackPointer_ff <= psc_pkg::ZERO;
            systemValue_ff <= psc_pkg::ZERO;
            virtualTablePointer_ff <= psc_pkg::ZERO;
        end else if (ok) begin
            case (callCode)
                // [RULE14] kernel pointer store
                psc_pkg::C_WRKGP: begin
                    kernelGlobalPointer_ff <= arg0;
                end
                // [RULE17] stack pointer store
                psc_pkg::C_WRUSP: begin
                    userStackPointer_ff <= arg0;
                end
                // [RULE18] system value store
                psc_pkg::C_WRVAL: begin
                    systemValue_ff <= arg0;
                end
                // [RULE19] table pointer store
                psc_pkg::C_WRVPT: begin
                    virtualTablePointer_ff <= arg0;
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Global pointer reload
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gpLoad_ff <= 1'b0;
            gpValue_ff <= psc_pkg::ZERO;
        end else begin
            // [RULE14] every exception reloads
            gpLoad_ff <= exceptionTaken;
            if (exceptionTaken) begin
                gpValue_ff <= kernelGlobalPointer_ff;
            end
        end
    end

    // ========================================
    // Entry vectors
    genvar gi;
    generate
        for (gi = 0; gi < psc_pkg::NVEC; gi++) begin : gVec
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    entryVector_ff[gi*64 +: 64] <= psc_pkg::ZERO;
                // [RULE10] selector match writes
                end else if (ok && callCode == psc_pkg::C_WRVEC &&
                             arg1 == 64'(gi)) begin
                    entryVector_ff[gi*64 +: 64] <= arg0;
                end
            end
        end
    endgenerate

    // ========================================
    // Machine check summary, set wins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            machineCheckSummary_ff <= psc_pkg::MC_RST;
        end else begin
            // [RULE15] clear ones, load enables
            if (ok && callCode == psc_pkg::C_WRMCS) begin
                machineCheckSummary_ff <= {
                    arg0[4:psc_pkg::MC_EN_LO],
                    (machineCheckSummary_ff[psc_pkg::MC_CLR_HI:0] &
                     ~arg0[psc_pkg::MC_CLR_HI:0]) | checkEvent};
            end else begin
                machineCheckSummary_ff[psc_pkg::MC_CLR_HI:0] <=
                    machineCheckSummary_ff[psc_pkg::MC_CLR_HI:0] |
                    checkEvent;
            end
        end
    end

    // ========================================
    // Cross cpu and monitor
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            crossCpuRequest_ff <= 1'b0;
            crossCpuTarget_ff <= psc_pkg::ZERO;
            perfRequest_ff <= 1'b0;
            perfArg0_ff <= psc_pkg::ZERO;
            perfArg1_ff <= psc_pkg::ZERO;
        end else begin
            // [RULE12] post, do not wait
            // [RULE13] call completes at once
            crossCpuRequest_ff <= ok && callCode == psc_pkg::C_WRIPI;
            if (ok && callCode == psc_pkg::C_WRIPI) begin
                crossCpuTarget_ff <= arg0;
            end
            // [RULE16] forward inputs
            perfRequest_ff <= ok && callCode == psc_pkg::C_PERF;
            if (ok && callCode == psc_pkg::C_PERF) begin
                perfArg0_ff <= arg0;
                perfArg1_ff <= arg1;
            end
        end
    end
endmodule

// ### tb/psc_call_unit_props.sv
// Assertions on the call unit ports
module psc_call_unit_props (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        callValid,
    input wire logic [3:0]  callCode,
    input wire logic [63:0] arg0,
    input wire logic [63:0] arg1,
    input wire logic        statusMode,
    input wire logic [2:0]  checkEvent,
    input wire logic        exceptionTaken,
    input wire logic [63:0] processBlockBase,
    input wire logic        callReady_ff,
    input wire logic        callDone_ff,
    input wire logic        reservedOpcodeFault_ff,
    input wire logic [63:0] result_ff,
    input wire logic [2:0]  interruptPriorityLevel_ff,
    input wire logic        floatEnable_ff,
    input wire logic [63:0] kernelGlobalPointer_ff,
    input wire logic [4:0]  machineCheckSummary_ff,
    input wire logic        gpLoad_ff,
    input wire logic [63:0] gpValue_ff,
    input wire logic        itbInvalidate_ff,
    input wire logic        dtbInvalidate_ff,
    input wire logic [63:0] tbAddress_ff,
    input wire logic        tbDropLocal_ff,
    input wire logic        tbFlushAll_ff,
    input wire logic        icacheFlush_ff,
    input wire logic        imageInit_ff,
    input wire logic        imageJump_ff,
    input wire logic        pcbWrite_ff,
    input wire logic [63:0] pcbAddress_ff,
    input wire logic        pcbData_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Helper terms
    logic kTake; // Kernel call taken
    logic uTake; // User call taken
    assign kTake = callValid && callReady_ff && !statusMode;
    assign uTake = callValid && callReady_ff && statusMode;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Tail of a successful image switch
    sequence s_swapTail;
        imageInit_ff && !callReady_ff ##1
        imageJump_ff && callDone_ff && callReady_ff;
    endsequence
    // ========================================
    // Properties
    a_user_fault: assert property (
        uTake |=> reservedOpcodeFault_ff && callDone_ff)
        else $error("user call did not fault");
    a_fault_quiet: assert property (
        uTake |=> $stable(result_ff) && !pcbWrite_ff && !icacheFlush_ff
        && $stable(interruptPriorityLevel_ff) && !itbInvalidate_ff)
        else $error("faulting call changed state");
    a_level_swap: assert property (
        kTake && callCode == 4'h0 |=> callDone_ff
        && result_ff == {61'h0, $past(interruptPriorityLevel_ff)}
        && interruptPriorityLevel_ff == $past(arg0[2:0]))
        else $error("level swap wrong");
    a_image_direct: assert property (
        kTake && callCode == 4'h1 && arg0 >= 64'h100
        |=> icacheFlush_ff && tbFlushAll_ff)
        else $error("direct base ignored");
    a_image_unknown: assert property (
        kTake && callCode == 4'h1 && arg0 < 64'h100 && arg0 > 64'h3
        |=> callDone_ff && result_ff == 64'h1 && !icacheFlush_ff)
        else $error("unknown variant status wrong");
    a_swap_order: assert property (
        icacheFlush_ff |-> tbFlushAll_ff && !callReady_ff ##1 s_swapTail)
        else $error("switch out of order");
    a_tb_decode: assert property (
        kTake && callCode == 4'h2 |=>
        itbInvalidate_ff == ($past(arg0) inside {64'h1, 64'h3})
        && dtbInvalidate_ff == ($past(arg0) inside {64'h2, 64'h3})
        && tbDropLocal_ff == ($past(arg0) == 64'hFFFF_FFFF_FFFF_FFFF)
        && tbFlushAll_ff == ($past(arg0) == 64'hFFFF_FFFF_FFFF_FFFE))
        else $error("invalidate decode wrong");
    a_float_copy: assert property (
        kTake && callCode == 4'h5 |=> pcbWrite_ff
        && floatEnable_ff == $past(arg0[0]) && pcbData_ff == $past(arg0[0])
        && pcbAddress_ff == $past(processBlockBase) + 64'h28)
        else $error("float enable copy wrong");
    a_kgp_exception: assert property (
        exceptionTaken && !(kTake && callCode == 4'h7) |=> gpLoad_ff
        && gpValue_ff == $past(kernelGlobalPointer_ff))
        else $error("global pointer not loaded");
    a_machine_check_summary_update: assert property (
        kTake && callCode == 4'h8 && checkEvent == 3'h0 |=>
        machineCheckSummary_ff[4:3] == $past(arg0[4:3])
        && (machineCheckSummary_ff[2:0] & $past(arg0[2:0])) == 3'h0)
        else $error("summary update wrong");
endmodule

bind psc_call_unit psc_call_unit_props u_props (.*);

// ### tb/tb_top.sv
// Self-checking bench for the privileged call unit
`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("FAIL %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Design signals
    logic         clock, rst_b, callValid, statusMode, exceptionTaken;
    logic [3:0]   callCode, imageLoaded;
    logic [63:0]  arg0, arg1, processBlockBase, perfResult;
    logic [5:0]   cpuNumber;
    logic [255:0] imageBases;
    logic [2:0]   checkEvent, interruptPriorityLevel_ff;
    logic         callReady_ff, callDone_ff, reservedOpcodeFault_ff;
    logic [63:0]  result_ff, kernelGlobalPointer_ff, userStackPointer_ff;
    logic [63:0]  systemValue_ff, virtualTablePointer_ff, gpValue_ff;
    logic [63:0]  tbAddress_ff, imageEntry_ff, pcbAddress_ff;
    logic [63:0]  crossCpuTarget_ff, perfArg0_ff, perfArg1_ff;
    logic         floatEnable_ff, gpLoad_ff, itbInvalidate_ff;
    logic         dtbInvalidate_ff, tbDropLocal_ff, tbFlushAll_ff;
    logic         icacheFlush_ff, imageInit_ff, imageJump_ff, pcbWrite_ff;
    logic         pcbData_ff, crossCpuRequest_ff, perfRequest_ff;
    logic [4:0]   machineCheckSummary_ff;
    logic [383:0] entryVector_ff, expVec;
    // ========================================
    // Bench state
    int          error_cnt = 0; // Mismatches
    int          tests_run = 0; // Comparisons
    logic [6:0]  side;          // Side pulses at completion
    logic [63:0] imgArg [6] = '{64'h1, 64'h4, 64'hFF, 64'h2, 64'h100, 64'h0};
    logic [63:0] imgSt [6] = '{64'h2, 64'h1, 64'h1, 64'h0, 64'h0, 64'h0};
    logic [63:0] imgEnt [6] = '{0, 0, 0, 64'hB000, 64'h100, 64'h9000};
    logic [63:0] tbSel [6] = '{1, 2, 3, '1, 64'hFFFF_FFFF_FFFF_FFFE, 5};
    logic [6:0]  tbExp [6] = '{7'h40, 7'h20, 7'h60, 7'h10, 7'h08, 7'h00};

    psc_call_unit DUT (.*);

    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Verdict
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One call, then wait for done
    task automatic doCall(input logic [3:0] c, input logic [63:0] a, b,
                          input logic u);
        int n;
        n = 0;
        @(negedge clock);
        callCode = c;
        arg0 = a;
        arg1 = b;
        statusMode = u;
        callValid = 1'b1;
        @(negedge clock);
        callValid = 1'b0;
        while (callDone_ff !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (n == 8) begin
            error_cnt++;
            $display("FAIL %0t call never completed", $time);
            end_of_test();
        end
        side = {itbInvalidate_ff, dtbInvalidate_ff, tbDropLocal_ff,
                tbFlushAll_ff, pcbWrite_ff, crossCpuRequest_ff,
                perfRequest_ff};
    endtask

    // ========================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        callValid = 1'b0;
        callCode = 4'h0;
        arg0 = 64'h0;
        arg1 = 64'h0;
        statusMode = 1'b0;
        cpuNumber = 6'h2A;
        processBlockBase = 64'h8000;
        imageLoaded = 4'h5;
        imageBases = {64'hC000, 64'hB000, 64'hA000, 64'h9000};
        checkEvent = 3'h0;
        exceptionTaken = 1'b0;
        perfResult = 64'h77;
        expVec = '0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        `CHK(interruptPriorityLevel_ff, 3'h7)
        `CHK(callReady_ff, 1'b1)
        doCall(4'h0, 64'h5, 64'h0, 1'b0);
        `CHK(result_ff, 64'h7)
        doCall(4'h0, 64'hFFFF_FFFF_FFFF_FFFA, 64'h0, 1'b0);
        `CHK({result_ff, interruptPriorityLevel_ff}, {64'h5, 3'h2})
        // Every call refused in user mode
        for (int c = 0; c < 14; c++) begin
            doCall(c[3:0], 64'h3, 64'h1, 1'b1);
            `CHK(reservedOpcodeFault_ff, 1'b1)
            `CHK({side, interruptPriorityLevel_ff}, 10'h2)
            `CHK(result_ff, 64'h5)
        end
        // Image switch by variant and by base
        for (int i = 0; i < 6; i++) begin
            doCall(4'h1, imgArg[i], 64'h0, 1'b0);
            `CHK(result_ff, imgSt[i])
            if (imgSt[i] == 64'h0) begin
                `CHK(imageEntry_ff, imgEnt[i])
            end
        end
        // Every invalidate selector
        for (int i = 0; i < 6; i++) begin
            doCall(4'h2, tbSel[i], 64'h4000 + 64'(i), 1'b0);
            `CHK(side, tbExp[i])
            if (i < 3) begin
                `CHK(tbAddress_ff, 64'h4000 + 64'(i))
            end
        end
        doCall(4'h3, 64'h0, 64'h0, 1'b0);
        `CHK(result_ff, 64'h2A)
        // All vector selectors, one ignored
        for (int s = 0; s < 7; s++) begin
            doCall(4'h4, 64'h1000 + 64'(s), 64'(s), 1'b0);
            if (s < 6) begin
                expVec[s*64 +: 64] = 64'h1000 + 64'(s);
            end
        end
        `CHK(entryVector_ff, expVec)
        doCall(4'h5, 64'h3, 64'h0, 1'b0);
        `CHK({side, floatEnable_ff, pcbData_ff}, 9'h13)
        `CHK(pcbAddress_ff, 64'h8028)
        doCall(4'h5, 64'h2, 64'h0, 1'b0);
        `CHK({floatEnable_ff, pcbData_ff}, 2'h0)
        doCall(4'h6, 64'h5, 64'h0, 1'b0);
        `CHK({side, crossCpuTarget_ff}, {7'h02, 64'h5})
        doCall(4'h7, 64'hDEAD0, 64'h0, 1'b0);
        exceptionTaken = 1'b1;
        @(negedge clock);
        exceptionTaken = 1'b0;
        `CHK({gpLoad_ff, gpValue_ff}, {1'b1, 64'hDEAD0})
        checkEvent = 3'h7;
        @(negedge clock);
        checkEvent = 3'h0;
        doCall(4'h8, 64'h0B, 64'h0, 1'b0);
        `CHK(machineCheckSummary_ff, 5'h0C)
        doCall(4'h9, 64'h11, 64'h22, 1'b0);
        `CHK({side, perfArg0_ff, perfArg1_ff}, {7'h1, 64'h11, 64'h22})
        `CHK(result_ff, 64'h77)
        doCall(4'hA, 64'h5000, 64'h0, 1'b0);
        `CHK(userStackPointer_ff, 64'h5000)
        doCall(4'hB, 64'h1234_5678_9ABC_DEF0, 64'h0, 1'b0);
        doCall(4'hD, 64'h0, 64'h0, 1'b0);
        `CHK(result_ff, 64'h1234_5678_9ABC_DEF0)
        doCall(4'hC, 64'h2000, 64'h0, 1'b0);
        `CHK(virtualTablePointer_ff, 64'h2000)
        end_of_test();
    end
endmodule
